// File: logic/tcpb_pkg.sv
package tcpb_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int unsigned NUM_CNT = 5;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned NUM_ALARM = 2;
    localparam int unsigned TAP_BITS = 4;
    localparam int unsigned NUM_TAPS = 4;

    // ****************************************
    // Register index map (data pointer values)
    // ****************************************
    localparam logic [4:0] IDX_MASTER = 5'h14;
    localparam logic [1:0] SUB_MODE = 2'h0;
    localparam logic [1:0] SUB_LOAD = 2'h1;
    localparam logic [1:0] SUB_ALARM = 2'h2;
    localparam logic [1:0] SUB_COUNT = 2'h3;

    // ****************************************
    // Master mode fields and reset values
    // ****************************************
    localparam int unsigned MM_DIV_LSB = 0;
    localparam int unsigned MM_SRC_LSB = 4;
    localparam int unsigned MM_OFF_BIT = 12;
    localparam int unsigned MM_BUS16_BIT = 14;
    localparam logic [15:0] MM_RESET = 16'h0000;
    localparam logic [15:0] CHAN_MODE_RESET = 16'h0000;
    localparam logic [15:0] LOAD_RESET = 16'h0000;

    // ****************************************
    // Count source codes
    // ****************************************
    localparam logic [3:0] SRC_SCALED_BASE = 4'h0;
    localparam logic [3:0] SRC_PIN_BASE = 4'h4;
    localparam logic [3:0] SRC_GATE_BASE = 4'h9;
    localparam logic [3:0] SRC_LAST = 4'hd;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        GM_NONE = 2'b00,
        GM_LEVEL = 2'b01,
        GM_EDGE = 2'b11,
        GM_FSEL = 2'b10
    } tcpb_gate_mode_e;

    typedef enum logic [1:0] {
        OM_PULSE = 2'b00,
        OM_TOGGLE = 2'b01,
        OM_IDLE = 2'b11,
        OM_HIZ = 2'b10
    } tcpb_out_mode_e;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_WRITE = 2'b01,
        ACC_READ = 2'b10
    } tcpb_acc_e;

    typedef struct packed {
        logic spare;
        logic alarm_en;
        logic out_pol;
        tcpb_out_mode_e out_mode;
        tcpb_gate_mode_e gate_mode;
        logic gate_pol;
        logic [2:0] gate_sel;
        logic src_pol;
        logic [3:0] src_sel;
    } tcpb_chan_cfg_s;

endpackage

// File: logic/tcpb_sync.sv
`timescale 1ns/1ns
module tcpb_sync #(
    parameter int unsigned WIDTH = 15
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Pins in and synchronised copy out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage is read only by the second
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

// File: logic/tcpb_chan.sv
`timescale 1ns/1ns
module tcpb_chan #(
    parameter int unsigned CNT_W = 16,
    parameter bit HAS_ALARM = 1'b0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Configuration
    input wire tcpb_pkg::tcpb_chan_cfg_s cfg_i,
    input wire logic [CNT_W-1:0] load_i,
    input wire logic [CNT_W-1:0] alarm_i,
    input wire logic load_strobe_i,
    input wire logic run_i,
    // Count events and gate
    input wire logic src_evt_i,
    input wire logic alt_evt_i,
    input wire logic gate_i,
    // Results
    output logic tc_o,
    output logic [CNT_W-1:0] count_o,
    output logic wave_o,
    output logic wave_oe_n_o
);

    logic gate_d_q;
    logic armed_q;
    logic tgl_q;
    logic tc_q;
    logic [CNT_W-1:0] count_q;
    logic wave_q;
    logic oe_n_q;
    logic evt;
    logic allow;
    logic adv;
    logic tc_now;
    logic level;

    always_comb begin
        evt = src_evt_i;
        allow = 1'b1;
        case (cfg_i.gate_mode)
            tcpb_pkg::GM_NONE: allow = 1'b1;
            tcpb_pkg::GM_LEVEL: allow = gate_i;
            tcpb_pkg::GM_EDGE: allow = armed_q;
            tcpb_pkg::GM_FSEL: evt = gate_i ? src_evt_i : alt_evt_i;
            default: allow = 1'b1;
        endcase
        adv = run_i & evt & allow;
        // Next state would be zero: reload instead
        tc_now = adv & (count_q <= CNT_W'(1));
    end

    // Edge-initiated gating stays armed until terminal count
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            gate_d_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            gate_d_q <= gate_i;
            if (gate_i & ~gate_d_q) begin
                armed_q <= 1'b1;
            end else if (tc_now) begin
                armed_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            count_q <= '0;
            tc_q <= 1'b0;
        end else begin
            tc_q <= tc_now;
            if (load_strobe_i) begin
                count_q <= load_i;
            end else if (tc_now) begin
                count_q <= load_i;
            end else if (adv) begin
                count_q <= count_q - CNT_W'(1);
            end
        end
    end

    always_comb begin
        case (cfg_i.out_mode)
            tcpb_pkg::OM_PULSE: level = tc_q;
            tcpb_pkg::OM_TOGGLE: level = tgl_q;
            default: level = 1'b0;
        endcase
        if (HAS_ALARM && cfg_i.alarm_en) begin
            level = (count_q == alarm_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tgl_q <= 1'b0;
            wave_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            if (tc_now) begin
                tgl_q <= ~tgl_q;
            end
            wave_q <= level ^ cfg_i.out_pol;
            oe_n_q <= (cfg_i.out_mode == tcpb_pkg::OM_HIZ) & ~(HAS_ALARM && cfg_i.alarm_en);
        end
    end

    assign tc_o = tc_q;
    assign count_o = count_q;
    assign wave_o = wave_q;
    assign wave_oe_n_o = oe_n_q;

endmodule

// File: logic/tcpb_top.sv
`timescale 1ns/1ns
// Operation
// - Frequency output divides its selected input by 1 to 16 via 4-bit field.
// - Frequency divider input picks one of 14 sources, scaled taps included.
// - Software turns frequency output on or off; off holds it low.
// - After reset frequency output uses first scaled tap divided by sixteen.
// - Each enable input can govern when its counter may advance.
// - One enable input may gate all five counters at once.
// - Enable inputs are also selectable as count sources everywhere.
// - Each counter holds its own polarity for its selected enable input.
// - Counters offer level gating, edge-initiated gating, or no gating.
// - A gating mode lets enable level choose between two counter frequencies.
// - In 8-bit bus mode an upper bus line qualifies each active enable.
// - Source pins route to any counter and divider with per-counter polarity.
// - Each counter drives a three-state pin with pulse or square waveform.
// - Each counter pin's active polarity is set independently.
// - Output logic detects the would-be-zero state to form waveforms.
// - Counters 1 and 2 may assert output while count equals alarm.
// - Host bus has 16 lines; high means one, low means zero.
// - Bus takes data on write with select, drives it on read with select.
// - With chip select inactive all bus lines stay high-impedance.
// - After reset bus is 8 bits wide until master mode selects 16.
// - First chip select clears power-on state; strobes ignored while deselected.
module tcpb_top #(
    parameter int unsigned NUM_CNT = tcpb_pkg::NUM_CNT,
    parameter int unsigned CNT_W = tcpb_pkg::CNT_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Host bus strobes
    input wire logic host_cs_n_i,
    input wire logic host_rd_n_i,
    input wire logic host_wr_n_i,
    input wire logic host_cd_i,
    // Host bus lines
    input wire logic [15:0] host_bus_line_i,
    output logic [15:0] host_bus_line_o,
    output logic [15:0] host_bus_line_oe_n_o,
    // Counter pins
    input wire logic [NUM_CNT-1:0] count_source_pin_i,
    input wire logic [NUM_CNT-1:0] count_enable_input_i,
    output logic [NUM_CNT-1:0] counter_wave_pin_o,
    output logic [NUM_CNT-1:0] counter_wave_pin_oe_n_o,
    // Frequency output and state
    output logic divided_freq_pin_o,
    output logic por_pending_o
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic pick_src(
        input logic [3:0] sel,
        input logic pol,
        input logic [NUM_CNT-1:0] src_rise,
        input logic [NUM_CNT-1:0] src_fall,
        input logic [NUM_CNT-1:0] gate_rise,
        input logic [NUM_CNT-1:0] gate_fall,
        input logic [tcpb_pkg::NUM_TAPS-1:0] taps
    );
        logic r;
        r = 1'b0;
        if (sel < tcpb_pkg::SRC_PIN_BASE) begin
            r = taps[2'(sel - tcpb_pkg::SRC_SCALED_BASE)];
        end else if (sel < tcpb_pkg::SRC_GATE_BASE) begin
            r = pol ? src_fall[3'(sel - tcpb_pkg::SRC_PIN_BASE)]
                    : src_rise[3'(sel - tcpb_pkg::SRC_PIN_BASE)];
        end else if (sel <= tcpb_pkg::SRC_LAST) begin
            r = pol ? gate_fall[3'(sel - tcpb_pkg::SRC_GATE_BASE)]
                    : gate_rise[3'(sel - tcpb_pkg::SRC_GATE_BASE)];
        end
        return r;
    endfunction

    function automatic logic [15:0] bus_read_byte(
        input logic [15:0] word,
        input logic bus16,
        input logic hi
    );
        logic [15:0] r;
        r = word;
        if (!bus16) begin
            r = {8'h00, hi ? word[15:8] : word[7:0]};
        end
        return r;
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    localparam int unsigned SYNC_W = 3 * NUM_CNT;

    logic [SYNC_W-1:0] pins_sync;
    logic [SYNC_W-1:0] pins_d_q;
    logic [NUM_CNT-1:0] src_s;
    logic [NUM_CNT-1:0] gate_s;
    logic [NUM_CNT-1:0] aux_s;
    logic [NUM_CNT-1:0] src_rise;
    logic [NUM_CNT-1:0] src_fall;
    logic [NUM_CNT-1:0] gate_rise;
    logic [NUM_CNT-1:0] gate_fall;

    tcpb_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .async_i({host_bus_line_i[8 +: NUM_CNT], count_enable_input_i, count_source_pin_i}),
        .sync_o(pins_sync)
    );

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pins_d_q <= '0;
        end else begin
            pins_d_q <= pins_sync;
        end
    end

    assign src_s = pins_sync[0 +: NUM_CNT];
    assign gate_s = pins_sync[NUM_CNT +: NUM_CNT];
    assign aux_s = pins_sync[2*NUM_CNT +: NUM_CNT];
    assign src_rise = src_s & ~pins_d_q[0 +: NUM_CNT];
    assign src_fall = ~src_s & pins_d_q[0 +: NUM_CNT];
    assign gate_rise = gate_s & ~pins_d_q[NUM_CNT +: NUM_CNT];
    assign gate_fall = ~gate_s & pins_d_q[NUM_CNT +: NUM_CNT];

    // ****************************************
    // Scaled oscillator taps
    // ****************************************
    localparam int unsigned PRE_W = tcpb_pkg::TAP_BITS * (tcpb_pkg::NUM_TAPS - 1);

    logic [PRE_W-1:0] pre_q;
    logic [tcpb_pkg::NUM_TAPS-1:0] taps;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + PRE_W'(1);
        end
    end

    // First tap is the core clock itself, each further tap one sixteenth of the last
    always_comb begin
        taps[0] = 1'b1;
        for (int k = 1; k < tcpb_pkg::NUM_TAPS; k++) begin
            taps[k] = &pre_q[k*tcpb_pkg::TAP_BITS-1 -: tcpb_pkg::TAP_BITS] & ((k == 1) ? 1'b1 : taps[k-1]);
        end
    end

    // ****************************************
    // Host access
    // ****************************************
    tcpb_pkg::tcpb_acc_e acc_q;
    logic [4:0] ptr_q;
    logic byte_hi_q;
    logic [7:0] lo_byte_q;
    logic [15:0] master_q;
    logic por_q;
    logic [15:0] mode_q [NUM_CNT];
    logic [CNT_W-1:0] load_q [NUM_CNT];
    logic [CNT_W-1:0] alarm_q [tcpb_pkg::NUM_ALARM];
    logic [NUM_CNT-1:0] load_strobe_q;
    logic [15:0] bus_out_q;
    logic [15:0] bus_oe_n_q;
    logic cs_act;
    logic wr_act;
    logic rd_act;
    logic bus16;
    logic commit;
    logic [15:0] wr_word;
    logic [15:0] rd_word;
    logic [2:0] ptr_cnt;
    logic [1:0] ptr_sub;
    logic [CNT_W-1:0] count_w [NUM_CNT];
    logic [NUM_CNT-1:0] wave_w;

    // Strobes count only while chip select is low
    assign cs_act = ~host_cs_n_i;
    assign wr_act = cs_act & ~host_wr_n_i;
    assign rd_act = cs_act & ~host_rd_n_i;
    assign bus16 = master_q[tcpb_pkg::MM_BUS16_BIT];
    assign ptr_cnt = ptr_q[4:2];
    assign ptr_sub = ptr_q[1:0];
    // Narrow bus pairs low byte then high byte; the word lands on the high byte
    assign commit = bus16 | byte_hi_q;
    assign wr_word = bus16 ? host_bus_line_i : {host_bus_line_i[7:0], lo_byte_q};

    always_comb begin
        rd_word = 16'h0000;
        if (host_cd_i) begin
            rd_word = {10'h000, por_q, wave_w};
        end else if (ptr_q == tcpb_pkg::IDX_MASTER) begin
            rd_word = master_q;
        end else if (32'(ptr_cnt) < NUM_CNT) begin
            case (ptr_sub)
                tcpb_pkg::SUB_MODE: rd_word = mode_q[ptr_cnt];
                tcpb_pkg::SUB_LOAD: rd_word = 16'(load_q[ptr_cnt]);
                tcpb_pkg::SUB_ALARM: rd_word = (32'(ptr_cnt) < tcpb_pkg::NUM_ALARM) ? 16'(alarm_q[ptr_cnt[0]]) : 16'h0000;
                tcpb_pkg::SUB_COUNT: rd_word = 16'(count_w[ptr_cnt]);
                default: rd_word = 16'h0000;
            endcase
        end
    end

    // Access sequencer: one take per strobe assertion
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            acc_q <= tcpb_pkg::ACC_IDLE;
        end else begin
            case (acc_q)
                tcpb_pkg::ACC_IDLE: begin
                    if (wr_act) begin
                        acc_q <= tcpb_pkg::ACC_WRITE;
                    end else if (rd_act) begin
                        acc_q <= tcpb_pkg::ACC_READ;
                    end
                end
                tcpb_pkg::ACC_WRITE: begin
                    if (!wr_act) begin
                        acc_q <= tcpb_pkg::ACC_IDLE;
                    end
                end
                tcpb_pkg::ACC_READ: begin
                    if (!rd_act) begin
                        acc_q <= tcpb_pkg::ACC_IDLE;
                    end
                end
                default: acc_q <= tcpb_pkg::ACC_IDLE;
            endcase
        end
    end

    // Power-on state lasts until the first chip select
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            por_q <= 1'b1;
        end else if (cs_act) begin
            por_q <= 1'b0;
        end
    end

    // Pointer and byte pairing
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ptr_q <= '0;
            byte_hi_q <= 1'b0;
            lo_byte_q <= 8'h00;
        end else if (acc_q == tcpb_pkg::ACC_IDLE && wr_act) begin
            if (host_cd_i) begin
                ptr_q <= host_bus_line_i[4:0];
                byte_hi_q <= 1'b0;
            end else if (!bus16) begin
                lo_byte_q <= host_bus_line_i[7:0];
                byte_hi_q <= ~byte_hi_q;
            end
        end else if (acc_q == tcpb_pkg::ACC_READ && !rd_act && !host_cd_i && !bus16) begin
            byte_hi_q <= ~byte_hi_q;
        end
    end

    // Register writes
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            master_q <= tcpb_pkg::MM_RESET;
            for (int n = 0; n < NUM_CNT; n++) begin
                mode_q[n] <= tcpb_pkg::CHAN_MODE_RESET;
                load_q[n] <= CNT_W'(tcpb_pkg::LOAD_RESET);
            end
            for (int n = 0; n < tcpb_pkg::NUM_ALARM; n++) begin
                alarm_q[n] <= '0;
            end
            load_strobe_q <= '0;
        end else begin
            load_strobe_q <= '0;
            if (acc_q == tcpb_pkg::ACC_IDLE && wr_act && !host_cd_i && commit) begin
                if (ptr_q == tcpb_pkg::IDX_MASTER) begin
                    master_q <= wr_word;
                end else if (32'(ptr_cnt) < NUM_CNT) begin
                    case (ptr_sub)
                        tcpb_pkg::SUB_MODE: mode_q[ptr_cnt] <= wr_word;
                        tcpb_pkg::SUB_LOAD: begin
                            load_q[ptr_cnt] <= CNT_W'(wr_word);
                            load_strobe_q[ptr_cnt] <= 1'b1;
                        end
                        tcpb_pkg::SUB_ALARM: begin
                            if (32'(ptr_cnt) < tcpb_pkg::NUM_ALARM) begin
                                alarm_q[ptr_cnt[0]] <= CNT_W'(wr_word);
                            end
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

    // Bus drivers: narrow mode never drives the upper lines
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            bus_out_q <= 16'h0000;
            bus_oe_n_q <= 16'hffff;
        end else begin
            bus_out_q <= bus_read_byte(rd_word, bus16, byte_hi_q);
            bus_oe_n_q[7:0] <= {8{~rd_act}};
            bus_oe_n_q[15:8] <= {8{~(rd_act & bus16)}};
        end
    end

    assign host_bus_line_o = bus_out_q;
    assign host_bus_line_oe_n_o = bus_oe_n_q;

    // ****************************************
    // Counters
    // ****************************************
    logic [NUM_CNT-1:0] tc_w;
    logic [NUM_CNT-1:0] oe_n_w;

    for (genvar n = 0; n < NUM_CNT; n++) begin : g_chan
        tcpb_pkg::tcpb_chan_cfg_s cfg;
        logic gate_q;
        logic evt_q;
        logic [2:0] gsel;

        assign cfg = tcpb_pkg::tcpb_chan_cfg_s'(mode_q[n]);
        assign gsel = (32'(cfg.gate_sel) < NUM_CNT) ? cfg.gate_sel : 3'(n);

        // Any counter may name any enable pin, so one pin can serve several
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                gate_q <= 1'b0;
                evt_q <= 1'b0;
            end else begin
                gate_q <= (gate_s[gsel] ^ cfg.gate_pol) & (bus16 | aux_s[gsel]);
                evt_q <= pick_src(cfg.src_sel, cfg.src_pol, src_rise, src_fall, gate_rise, gate_fall, taps);
            end
        end

        tcpb_chan #(
            .CNT_W(CNT_W),
            .HAS_ALARM(n < tcpb_pkg::NUM_ALARM)
        ) u_chan (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .cfg_i(cfg),
            .load_i(load_q[n]),
            .alarm_i((n < tcpb_pkg::NUM_ALARM) ? alarm_q[n % tcpb_pkg::NUM_ALARM] : '0),
            .load_strobe_i(load_strobe_q[n]),
            .run_i(~por_q),
            .src_evt_i(evt_q),
            .alt_evt_i(tc_w[(n + NUM_CNT - 1) % NUM_CNT]),
            .gate_i(gate_q),
            .tc_o(tc_w[n]),
            .count_o(count_w[n]),
            .wave_o(wave_w[n]),
            .wave_oe_n_o(oe_n_w[n])
        );
    end

    assign counter_wave_pin_o = wave_w;
    assign counter_wave_pin_oe_n_o = oe_n_w;

    // ****************************************
    // Frequency output divider
    // ****************************************
    logic [3:0] fdiv_q;
    logic divided_freq_pin_q;
    logic fevt_q;
    logic [3:0] div_m1;
    logic [4:0] fhalf;

    // Field zero means sixteen: the wrap of field-1 gives the top count
    assign div_m1 = master_q[tcpb_pkg::MM_DIV_LSB +: 4] - 4'h1;
    assign fhalf = 5'(({1'b0, div_m1} + 5'h2) >> 1);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            fevt_q <= 1'b0;
            fdiv_q <= 4'hf;
            divided_freq_pin_q <= 1'b0;
        end else begin
            fevt_q <= pick_src(master_q[tcpb_pkg::MM_SRC_LSB +: 4], 1'b0, src_rise, src_fall,
                               gate_rise, gate_fall, taps);
            if (fevt_q) begin
                fdiv_q <= (fdiv_q >= div_m1) ? 4'h0 : fdiv_q + 4'h1;
            end
            divided_freq_pin_q <= ~master_q[tcpb_pkg::MM_OFF_BIT] & ({1'b0, fdiv_q} < fhalf);
        end
    end

    assign divided_freq_pin_o = divided_freq_pin_q;
    assign por_pending_o = por_q;

endmodule

// File: verif/tcpb_host.sv
`timescale 1ns/1ns
module tcpb_host (
    // Clock and device side
    input wire logic clk_i,
    input wire logic [15:0] dev_i,
    input wire logic [15:0] dev_oe_n_i,
    // Strobes and lines
    output logic cs_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic cd_o,
    output logic [15:0] line_o
);
    logic [15:0] hv = 16'h00ff;
    logic drv = 1'b0;
    initial {cs_n_o, rd_n_o, wr_n_o, cd_o} = 4'hf;
    // Released lines read inverted; spare enables idle high
    assign line_o = (dev_i & ~dev_oe_n_i) | ((drv ? hv : {8'hff, ~hv[7:0]}) & dev_oe_n_i);
    task automatic wr(input logic c, input logic [15:0] v);
        @(posedge clk_i);
        {cs_n_o, wr_n_o, cd_o, drv, hv} <= {2'b00, c, 1'b1, v};
        @(posedge clk_i);
        {cs_n_o, wr_n_o, drv} <= 3'b110;
    endtask
    task automatic rd(input logic c, output logic [31:0] r);
        @(posedge clk_i);
        {cs_n_o, rd_n_o, cd_o} <= {2'b00, c};
        repeat (2) @(posedge clk_i);
        r = {dev_oe_n_i, dev_i};
        {cs_n_o, rd_n_o} <= 2'b11;
    endtask
endmodule

// File: verif/tcpb_chk.sv
`timescale 1ns/1ns
module tcpb_chk #(
    parameter int unsigned NUM_CNT = 5
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Host bus
    input wire logic host_cs_n_i,
    input wire logic host_rd_n_i,
    input wire logic host_wr_n_i,
    input wire logic [15:0] host_bus_line_oe_n_o,
    // Pins and state
    input wire logic [NUM_CNT-1:0] counter_wave_pin_o,
    input wire logic divided_freq_pin_o,
    input wire logic por_pending_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    sequence s_rd; !host_cs_n_i && !host_rd_n_i; endsequence
    sequence s_wr; !host_cs_n_i && !host_wr_n_i && host_rd_n_i; endsequence
    sequence s_sq16; divided_freq_pin_o [*8] ##1 !divided_freq_pin_o [*8] ##1 divided_freq_pin_o; endsequence
    AST_BUS_DRIVE: assert property (s_rd |=> host_bus_line_oe_n_o[7:0] == 8'h00) else $error("read undriven");
    AST_WR_QUIET: assert property (s_wr |=> &host_bus_line_oe_n_o) else $error("driven on write");
    AST_DESEL_HIZ: assert property (host_cs_n_i |=> &host_bus_line_oe_n_o) else $error("driven idle");
    AST_UPPER_HIZ: assert property (por_pending_o |-> &host_bus_line_oe_n_o[15:8]) else $error("upper driven");
    AST_POR_CLEAR: assert property (!host_cs_n_i |=> !por_pending_o) else $error("por kept");
    AST_POR_HOLD: assert property (por_pending_o && host_cs_n_i |=> por_pending_o) else $error("por lost");
    AST_DIVIDED_FREQ_PIN_RST: assert property (por_pending_o && $rose(divided_freq_pin_o) |-> s_sq16) else $error("divided_freq_pin");
    AST_WAVE_IDLE: assert property (por_pending_o |-> counter_wave_pin_o == '0) else $error("early count");
endmodule
bind tcpb_top tcpb_chk #(.NUM_CNT(NUM_CNT)) i_tcpb_chk (
    .clk_i(clk_i), .srst_i(srst_i), .host_cs_n_i(host_cs_n_i), .host_rd_n_i(host_rd_n_i),
    .host_wr_n_i(host_wr_n_i), .host_bus_line_oe_n_o(host_bus_line_oe_n_o),
    .counter_wave_pin_o(counter_wave_pin_o), .divided_freq_pin_o(divided_freq_pin_o),
    .por_pending_o(por_pending_o)
);

// File: verif/tb.sv
`timescale 1ns/1ns
module tb;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [4:0] src = 5'h00;
    logic [4:0] gate = 5'h00;
    logic [15:0] bus, dout, doe_n;
    logic cs_n, rd_n, wr_n, cd, divided_freq_pin, por;
    logic [4:0] wave, woe_n;
    logic [5:0] mon, pv;
    logic [31:0] r;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    int p;
    logic [15:0] mm_row [4] = '{16'h4002, 16'h4003, 16'h4000, 16'h4012};
    int per_row [4] = '{2, 3, 16, 32};
    assign mon = {divided_freq_pin, wave};
    tcpb_top i_tcpb_top (.clk_i(clk_i), .srst_i(srst_i), .host_cs_n_i(cs_n), .host_rd_n_i(rd_n),
        .host_wr_n_i(wr_n), .host_cd_i(cd), .host_bus_line_i(bus), .host_bus_line_o(dout),
        .host_bus_line_oe_n_o(doe_n), .count_source_pin_i(src), .count_enable_input_i(gate),
        .counter_wave_pin_o(wave), .counter_wave_pin_oe_n_o(woe_n), .divided_freq_pin_o(divided_freq_pin), .por_pending_o(por));
    tcpb_host i_tcpb_host (.clk_i(clk_i), .dev_i(dout), .dev_oe_n_i(doe_n), .cs_n_o(cs_n), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .cd_o(cd), .line_o(bus));
    initial forever #5 clk_i = ~clk_i;
    // Two-cycle source pulses, well above the minimum width
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        pv <= mon;
        src[0] <= cyc[1];
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic setr(input logic [4:0] idx, input logic [15:0] v);
        i_tcpb_host.wr(1'b1, {11'h000, idx});
        i_tcpb_host.wr(1'b0, v);
    endtask
    // Rise-to-rise cycles of mon[k], 0 when it stops
    task automatic per(input int k, output int n);
        int c = 0;
        int t0 = 0;
        repeat (3) begin
            do begin
                @(posedge clk_i);
                c++;
            end while (!(mon[k] === 1'b1 && pv[k] === 1'b0) && c < 400);
            n = (c >= 400) ? 0 : c - t0;
            t0 = c;
        end
    endtask
    task automatic results();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (30) @(posedge clk_i);
        per(5, p);
        chk({por, p[7:0]}, {1'b1, 8'h10});
        i_tcpb_host.rd(1'b1, r);
        chk({r[31:16], r[4:0]}, {16'hff00, 5'h00});
        i_tcpb_host.wr(1'b1, 16'hff14);
        i_tcpb_host.wr(1'b0, 16'hff00);
        i_tcpb_host.wr(1'b0, 16'hff40);
        for (int i = 0; i < 4; i++) begin
            setr(5'h14, mm_row[i]);
            per(5, p);
            chk(p, per_row[i]);
        end
        setr(5'h14, 16'h5000);
        per(5, p);
        chk({divided_freq_pin, p[7:0]}, 9'h000);
        setr(5'h01, 16'h0005);
        for (int g = 0; g < 4; g++) begin
            gate[0] <= g[0];
            setr(5'h00, {7'h00, g[1], 8'h00} | 16'h0200);
            per(0, p);
            chk(p, (g[0] ^ g[1]) ? 5 : 0);
        end
        setr(5'h00, 16'h2000);
        repeat (9) @(posedge clk_i);
        p = 0;
        repeat (10) @(posedge clk_i) p += wave[0];
        chk(p, 8);
        setr(5'h00, 16'h0004);
        setr(5'h01, 16'h0003);
        per(0, p);
        chk(p, 12);
        i_tcpb_host.wr(1'b1, 16'h0001);
        i_tcpb_host.rd(1'b0, r);
        chk(r, 32'h0000_0003);
        setr(5'h02, 16'h0002);
        setr(5'h00, 16'h4000);
        per(0, p);
        chk(p, 3);
        setr(5'h00, 16'h1000);
        repeat (3) @(posedge clk_i);
        chk(woe_n, 5'h01);
        srst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        chk({por, doe_n, woe_n}, 22'h3fffff);
        results();
    end
endmodule
